// ---- rtl/sar_pkg.sv ----
// Package with register map, field positions and timing for the converter control.
package sar_pkg;
    // Register indices and their byte addresses on the bus.
    localparam int          ADDR_W       = 12;
    localparam logic [31:0] IDX_CTRL     = 32'hffff8807;
    localparam logic [31:0] IDX_RESULT   = 32'hffff8809;
    localparam logic [31:0] IDX_LEVEL    = 32'h00000010;
    localparam logic [31:0] IDX_STATUS   = 32'h00000011;
    localparam logic [31:0] IDX_MASK     = 32'h00000012;
    localparam logic [ADDR_W-1:0] A_CTRL   = {IDX_CTRL[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] A_RESULT = {IDX_RESULT[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] A_LEVEL  = {IDX_LEVEL[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] A_STATUS = {IDX_STATUS[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] A_MASK   = {IDX_MASK[ADDR_W-3:0], 2'b00};
    // Control register fields.
    localparam int B_ENABLE = 6;
    localparam int B_DONE   = 4;
    localparam int B_START  = 3;
    localparam int B_CH_HI  = 1;
    localparam int B_CH_LO  = 0;
    // Widths and counts.
    localparam int RES_W    = 8;
    localparam int NUM_CH   = 4;
    localparam int CH_W     = 2;
    localparam int LEVEL_W  = 3;
    localparam int EVT_W    = 2;
    localparam int EV_DONE  = 0;
    localparam int EV_ABORT = 1;
    localparam int CONV_PERIODS = 24;
    localparam int SEC_CLK_DIV  = 4;
    // Reset values.
    localparam logic [RES_W-1:0]   RST_RESULT = 8'h00;
    localparam logic [LEVEL_W-1:0] RST_LEVEL  = 3'h0;
    localparam logic [EVT_W-1:0]   RST_EVT    = 2'h0;
    localparam logic [CH_W-1:0]    RST_CH     = 2'h0;
    // Sequencer states.
    typedef enum logic {sar_idle, sar_run} sar_state_e;
endpackage : sar_pkg

// ---- rtl/sar_conv_seq.sv ----
// Conversion sequencer: secondary clock divider and conversion period counter.
`timescale 1ns/1ps
module sar_conv_seq #(
    parameter int DIV     = sar_pkg::SEC_CLK_DIV,
    parameter int PERIODS = sar_pkg::CONV_PERIODS
) (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // Control.
    input  wire logic start,
    input  wire logic abort,
    // Status.
    output logic      busy,
    output logic      done,
    output logic      sec_tick
);
    localparam int DW = $clog2(DIV + 1);
    localparam int PW = $clog2(PERIODS + 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);
    localparam logic [PW-1:0] PER_LAST = PW'(PERIODS - 1);

    sar_pkg::sar_state_e state_r;
    sar_pkg::sar_state_e state_nxt;
    logic [DW-1:0]       div_r;
    logic [PW-1:0]       per_r;
    wire logic           last_tick;

    // Free running divider gives one enable pulse per secondary clock period.
    assign sec_tick  = (div_r == DIV_LAST);
    assign last_tick = sec_tick && (per_r == PER_LAST);
    assign busy      = (state_r == sar_pkg::sar_run);
    assign done      = busy && last_tick && !abort;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            sar_pkg::sar_idle: begin
                if (start && !abort) begin
                    state_nxt = sar_pkg::sar_run;
                end
            end
            sar_pkg::sar_run: begin
                if (abort || last_tick) begin
                    state_nxt = sar_pkg::sar_idle;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r <= sar_pkg::sar_idle;
            div_r   <= '0;
            per_r   <= '0;
        end else begin
            state_r <= state_nxt;
            div_r   <= sec_tick ? '0 : div_r + 1'b1;
            if (!busy) begin
                per_r <= '0;
            end else if (sec_tick) begin
                per_r <= per_r + 1'b1;
            end
        end
    end
endmodule : sar_conv_seq

// ---- rtl/sar_converter_control.sv ----
// Control, status, result and interrupt logic of the successive approximation converter.
//
// Behaviour
// R01: A conversion completes exactly 24 secondary clock periods after its start.
// R02: On completion the 8-bit result is stored and the done flag set.
// R03: The stored result is not overwritten while the done flag is high.
// R04: Starts while busy or done are high are dropped, not queued.
// R05: Entering power-down aborts a conversion in progress.
// R06: Power-down switches off the converter reference current.
// R07: Bit 6 enables the converter; clear disables it and switches reference off.
// R08: Bit 4, the done flag, sets when a result is ready.
// R09: Interrupt comes from the done flag only when the priority level is non-zero; irq here comes from status_r masked by mask_r.
// R10: Software clears the done flag before a new start; writes cannot set it.
// R11: Writing one to bit 3 starts a conversion; it reads high while busy.
// R12: Busy clears as done sets; software cannot clear busy.
// R13: Bits 1 and 0 select one of four inputs, bit 1 most significant.
// R14: The channel field changes only while busy and done are both low.
// R15: Software writes zero to control bits 7, 5 and 2.
// R16: Busy and done read high together for at most one cycle.
// R17: The multiplexer offers exactly four analog input channels.
// R18: After reset enable, busy, done and channel select read zero.
`timescale 1ns/1ps
module sar_converter_control #(
    parameter int DIV     = sar_pkg::SEC_CLK_DIV,
    parameter int PERIODS = sar_pkg::CONV_PERIODS
) (
    // Clock and reset.
    input  wire logic                       sys_clk,
    input  wire logic                       sys_rst,
    // APB slave.
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [sar_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Power control.
    input  wire logic                       power_down,
    // Analog core.
    input  wire logic [sar_pkg::RES_W-1:0]  ana_result,
    output logic      [sar_pkg::CH_W-1:0]   ana_ch_sel,
    output logic                            ana_ref_on,
    output logic                            ana_step_en,
    // Interrupt.
    output logic                            irq
);
    // Registers.
    logic                           enable_r;
    logic                           done_r;
    logic [sar_pkg::CH_W-1:0]       ch_r;
    logic [sar_pkg::RES_W-1:0]      result_r;
    logic [sar_pkg::LEVEL_W-1:0]    level_r;
    logic [sar_pkg::EVT_W-1:0]      status_r;
    logic [sar_pkg::EVT_W-1:0]      mask_r;
    logic [31:0]                    prdata_r;
    logic                           err_r;
    logic                           pd_r;

    // Next values.
    logic                           enable_nxt;
    logic                           done_nxt;
    logic [sar_pkg::CH_W-1:0]       ch_nxt;
    logic [sar_pkg::RES_W-1:0]      result_nxt;
    logic [sar_pkg::EVT_W-1:0]      status_nxt;

    // Decoded bus strobes.
    wire logic                      setup;
    wire logic                      access;
    wire logic                      wr;
    wire logic                      rd;
    wire logic                      sel_ctrl;
    wire logic                      sel_result;
    wire logic                      sel_level;
    wire logic                      sel_status;
    wire logic                      sel_mask;
    wire logic                      mapped;
    wire logic                      wr_ctrl;
    wire logic [31:0]               rd_mux;
    wire logic [7:0]                ctrl_view;

    // Conversion control.
    wire logic                      busy;
    wire logic                      conv_done;
    wire logic                      sec_tick;
    wire logic                      start_req;
    wire logic                      start_ok;
    wire logic                      abort;
    wire logic                      pd_enter;
    wire logic                      idle;
    wire logic [sar_pkg::EVT_W-1:0] events;
    wire logic [sar_pkg::EVT_W-1:0] rd_clear;

    function automatic logic hit(input logic [sar_pkg::ADDR_W-1:0] a,
                                 input logic [sar_pkg::ADDR_W-1:0] r);
        hit = (a == r);
    endfunction : hit

    function automatic logic [31:0] zext8(input logic [7:0] v);
        zext8 = {24'h000000, v};
    endfunction : zext8

    assign setup      = psel && !penable;
    assign access     = psel && penable;
    assign wr         = access && pwrite;
    assign rd         = access && !pwrite;
    assign sel_ctrl   = hit(paddr, sar_pkg::A_CTRL);
    assign sel_result = hit(paddr, sar_pkg::A_RESULT);
    assign sel_level  = hit(paddr, sar_pkg::A_LEVEL);
    assign sel_status = hit(paddr, sar_pkg::A_STATUS);
    assign sel_mask   = hit(paddr, sar_pkg::A_MASK);
    assign mapped     = sel_ctrl || sel_result || sel_level || sel_status || sel_mask;
    assign wr_ctrl    = wr && sel_ctrl;

    // Reserved control bits read as zero.
    assign ctrl_view = {1'b0, enable_r, 1'b0, done_r, busy, 1'b0, ch_r};
    assign rd_mux    = sel_ctrl   ? zext8(ctrl_view) :
                       sel_result ? zext8(result_r) :
                       sel_level  ? {29'h0000000, level_r} :
                       sel_status ? {30'h00000000, status_r} :
                       sel_mask   ? {30'h00000000, mask_r} : 32'h00000000;

    // Zero wait state slave; read data was captured in the setup cycle.
    assign pready  = 1'b1;
    assign prdata  = prdata_r;
    assign pslverr = access && err_r;

    // Start only when enabled, idle, flag clear and not powered down.
    assign idle      = !busy && !done_r;                                       // [R14]
    assign start_req = wr_ctrl && pwdata[sar_pkg::B_START];                    // [R11]
    assign start_ok  = start_req && idle && enable_r && !power_down;           // [R04]
    assign pd_enter  = power_down && !pd_r;
    assign abort     = pd_enter || power_down || !enable_r;                    // [R05] [R07]

    sar_conv_seq #(
        .DIV     (DIV),
        .PERIODS (PERIODS)
    ) u_seq (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .start    (start_ok),
        .abort    (abort),
        .busy     (busy),
        .done     (conv_done),
        .sec_tick (sec_tick)
    );                                                                         // [R01] [R12]

    // Analog side.
    assign ana_ch_sel  = ch_r;                                                 // [R13] [R17]
    assign ana_ref_on  = enable_r && !power_down;                              // [R06] [R07]
    assign ana_step_en = busy && sec_tick;

    // Event and interrupt logic.
    assign events   = {busy && abort, conv_done};
    assign rd_clear = (rd && sel_status) ? prdata_r[sar_pkg::EVT_W-1:0] : '0;
    assign irq      = (|(status_r & mask_r)) && (level_r != '0);               // [R09]

    always_comb begin
        enable_nxt = enable_r;
        done_nxt   = done_r;
        ch_nxt     = ch_r;
        result_nxt = result_r;
        status_nxt = (status_r & ~rd_clear) | events;
        if (wr_ctrl) begin
            enable_nxt = pwdata[sar_pkg::B_ENABLE];
            if (!pwdata[sar_pkg::B_DONE]) begin
                done_nxt = 1'b0;                                               // [R10]
            end
            if (idle) begin
                ch_nxt = pwdata[sar_pkg::B_CH_HI:sar_pkg::B_CH_LO];            // [R14]
            end
        end
        if (conv_done && !done_r) begin
            done_nxt   = 1'b1;                                                 // [R08]
            result_nxt = ana_result;                                           // [R02] [R03]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            enable_r <= 1'b0;                                                  // [R18]
            done_r   <= 1'b0;
            ch_r     <= sar_pkg::RST_CH;
            result_r <= sar_pkg::RST_RESULT;
            status_r <= sar_pkg::RST_EVT;
            pd_r     <= 1'b0;
        end else begin
            enable_r <= enable_nxt;
            done_r   <= done_nxt;
            ch_r     <= ch_nxt;
            result_r <= result_nxt;
            status_r <= status_nxt;
            pd_r     <= power_down;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            level_r <= sar_pkg::RST_LEVEL;
            mask_r  <= sar_pkg::RST_EVT;
        end else if (wr && sel_level) begin
            level_r <= pwdata[sar_pkg::LEVEL_W-1:0];
        end else if (wr && sel_mask) begin
            mask_r  <= pwdata[sar_pkg::EVT_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prdata_r <= 32'h00000000;
            err_r    <= 1'b0;
        end else if (setup) begin
            prdata_r <= pwrite ? 32'h00000000 : rd_mux;
            err_r    <= !mapped;
        end
    end

    // Checks.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    logic [15:0] run_cnt_r;
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !busy) begin
            run_cnt_r <= 16'h0000;
        end else if (sec_tick) begin
            run_cnt_r <= run_cnt_r + 16'h0001;
        end
    end

    a_conv_length: assert property (                                           // [R01]
        conv_done |-> (run_cnt_r == 16'(PERIODS - 1)) && sec_tick)
        else $error("conversion did not last the set number of periods");

    a_done_loads_result: assert property (                                     // [R02]
        (conv_done && !done_r) |=> done_r && (result_r == $past(ana_result)))
        else $error("completion did not store result and set flag");

    a_result_held: assert property (                                           // [R03]
        done_r |=> $stable(result_r))
        else $error("result changed while done flag high");

    a_start_dropped: assert property (                                         // [R04]
        (start_req && !idle) |=> (busy == $past(busy)) || !busy)
        else $error("blocked start began a conversion");

    a_pd_aborts: assert property (                                             // [R05]
        (busy && power_down) |=> !busy && !done_r)
        else $error("power down did not abort conversion");

    a_ref_off: assert property (                                               // [R06]
        (power_down || !enable_r) |-> !ana_ref_on)
        else $error("reference on while powered down or disabled");

    a_done_no_set: assert property (                                           // [R10]
        (!done_r && !conv_done) |=> !done_r)
        else $error("done flag set without a completion");

    a_busy_start: assert property (                                            // [R11]
        start_ok |=> busy ##1 (busy || $past(abort)))
        else $error("accepted start did not hold busy");

    a_busy_to_done: assert property (                                          // [R12]
        conv_done && !done_r |=> !busy && done_r)
        else $error("busy and done did not swap together");

    a_chan_locked: assert property (                                           // [R14]
        !idle |=> $stable(ch_r))
        else $error("channel changed while busy or done");

    a_flags_exclusive: assert property (                                       // [R16]
        !(busy && done_r))
        else $error("busy and done high together");

    a_irq_level: assert property (                                             // [R09]
        (level_r == '0) |-> !irq)
        else $error("interrupt with zero priority level");

    a_status_sticky: assert property (
        conv_done |=> status_r[sar_pkg::EV_DONE])
        else $error("completion did not set status bit");

endmodule : sar_converter_control

// ---- sim/sar_core_model.sv ----
// Behavioural model of the four input multiplexer and converter core.
`timescale 1ns/1ps
module sar_core_model (
    // Clock.
    input  wire logic                                sys_clk,
    // Control from the block.
    input  wire logic [sar_pkg::CH_W-1:0]            ana_ch_sel,
    input  wire logic                                ana_ref_on,
    // Levels on the four inputs.
    input  wire logic [3:0][sar_pkg::RES_W-1:0]      ch_level,
    // Result to the block.
    output logic      [sar_pkg::RES_W-1:0]           ana_result
);
    logic [sar_pkg::RES_W-1:0] last_r = 8'h00;

    // Without reference current the result is garbage that changes every cycle.
    always @(posedge sys_clk) begin
        if (ana_ref_on === 1'b1) begin
            last_r <= ch_level[ana_ch_sel];
        end else begin
            last_r <= ~last_r;
        end
    end
    assign ana_result = last_r;
endmodule : sar_core_model

// ---- sim/sar_converter_control_tb_top.sv ----
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
module sar_converter_control_tb_top;
    localparam int DIV = 4;
    localparam int PER = 6;
    logic              sys_clk    = 1'b0;
    logic              sys_rst    = 1'b1;
    logic              psel       = 1'b0;
    logic              penable    = 1'b0;
    logic              pwrite     = 1'b0;
    logic [11:0]       paddr      = 12'h000;
    logic [31:0]       pwdata     = 32'h0;
    logic              power_down = 1'b0;
    logic [3:0][7:0]   lvl        = '0;
    logic [31:0]       prdata;
    logic [31:0]       rd;
    logic              pready;
    logic              pslverr;
    logic              slv_err;
    logic              ana_ref_on;
    logic              ana_step_en;
    logic              irq;
    logic [7:0]        ana_result;
    logic [7:0]        old_res;
    logic [1:0]        ana_ch_sel;
    logic [1:0]        ch;
    int                num_errors = 0;
    int                tests_run  = 0;
    int                steps      = 0;
    int                cycles     = 0;

    always #5 sys_clk = ~sys_clk;

    sar_converter_control #(.DIV(DIV), .PERIODS(PER)) u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_down(power_down),
        .ana_result(ana_result), .ana_ch_sel(ana_ch_sel), .ana_ref_on(ana_ref_on),
        .ana_step_en(ana_step_en), .irq(irq)
    );

    sar_core_model u_core (
        .sys_clk(sys_clk), .ana_ch_sel(ana_ch_sel), .ana_ref_on(ana_ref_on),
        .ch_level(lvl), .ana_result(ana_result)
    );

    // Step pulses are counted so the conversion length can be checked in periods.
    always @(posedge sys_clk) begin
        if (ana_step_en === 1'b1) begin
            steps <= steps + 1;
        end
    end

    // A hang counts as a mismatch and ends the run.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    function automatic logic [31:0] ctl(input logic en, input logic dn, input logic bs,
                                        input logic [1:0] c);
        return {25'h0, en, 1'b0, dn, bs, 1'b0, c};
    endfunction : ctl

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd      = prdata;
        slv_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask : rdc

    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        chk("irq_wait", 32'h1, {31'h0, irq});
    endtask : wait_irq

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    initial begin
        void'($urandom(32'ha138));
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rdc("ctrl_reset", sar_pkg::A_CTRL, 32'h0);
        rdc("result_reset", sar_pkg::A_RESULT, 32'h0);
        chk("ref_reset", 32'h0, {31'h0, ana_ref_on});
        apb(1'b0, 12'hffc, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, slv_err});
        chk("unmapped_data", 32'h0, rd);
        $display("test reset and map done");
        apb(1'b1, sar_pkg::A_LEVEL, 32'h1);
        apb(1'b1, sar_pkg::A_MASK, 32'h1);
        for (int i = 0; i < 4; i++) begin
            ch = i[1:0];
            lvl[ch] <= 8'($urandom);
            apb(1'b1, sar_pkg::A_CTRL, {24'h0, 8'h40 | 8'(ch)});
            @(posedge sys_clk);
            chk("ch_sel", {30'h0, ch}, {30'h0, ana_ch_sel});
            steps = 0;
            apb(1'b1, sar_pkg::A_CTRL, {24'h0, 8'h48 | 8'(ch)});
            rdc("busy", sar_pkg::A_CTRL, ctl(1, 0, 1, ch));
            apb(1'b1, sar_pkg::A_CTRL, {24'h0, 8'h48 | {6'h00, ~ch}});
            rdc("busy_hold", sar_pkg::A_CTRL, ctl(1, 0, 1, ch));
            wait_irq();
            chk("periods", PER, steps);
            rdc("done", sar_pkg::A_CTRL, ctl(1, 1, 0, ch));
            old_res = lvl[ch];
            rdc("result", sar_pkg::A_RESULT, {24'h0, old_res});
            lvl[ch] <= ~old_res;
            apb(1'b1, sar_pkg::A_CTRL, {24'h0, 8'h58 | 8'(ch ^ 2'h1)});
            repeat (PER * DIV * 2) @(posedge sys_clk);
            rdc("blocked", sar_pkg::A_CTRL, ctl(1, 1, 0, ch));
            rdc("result_kept", sar_pkg::A_RESULT, {24'h0, old_res});
            rdc("status", sar_pkg::A_STATUS, 32'h1);
            rdc("status_clr", sar_pkg::A_STATUS, 32'h0);
            chk("irq_clr", 32'h0, {31'h0, irq});
            apb(1'b1, sar_pkg::A_CTRL, {24'h0, 8'h40 | 8'(ch)});
            apb(1'b1, sar_pkg::A_CTRL, {24'h0, 8'h50 | 8'(ch)});
            rdc("done_clear", sar_pkg::A_CTRL, ctl(1, 0, 0, ch));
        end
        $display("test channels done");
        apb(1'b1, sar_pkg::A_CTRL, 32'h48);
        power_down <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk("ref_pd", 32'h0, {31'h0, ana_ref_on});
        rdc("abort", sar_pkg::A_CTRL, ctl(1, 0, 0, 0));
        power_down <= 1'b0;
        repeat (PER * DIV * 2) @(posedge sys_clk);
        rdc("abort_kept", sar_pkg::A_CTRL, ctl(1, 0, 0, 0));
        rdc("status_abort", sar_pkg::A_STATUS, 32'h2);
        $display("test power down done");
        apb(1'b1, sar_pkg::A_LEVEL, 32'h0);
        apb(1'b1, sar_pkg::A_CTRL, 32'h48);
        repeat (PER * DIV * 2) @(posedge sys_clk);
        chk("irq_level0", 32'h0, {31'h0, irq});
        rdc("done_level0", sar_pkg::A_CTRL, ctl(1, 1, 0, 0));
        apb(1'b1, sar_pkg::A_LEVEL, {29'h0, 3'($urandom_range(7, 1))});
        @(posedge sys_clk);
        chk("irq_level", 32'h1, {31'h0, irq});
        rdc("status_done", sar_pkg::A_STATUS, 32'h1);
        $display("test interrupt level done");
        apb(1'b1, sar_pkg::A_CTRL, 32'h0);
        @(posedge sys_clk);
        chk("ref_off", 32'h0, {31'h0, ana_ref_on});
        apb(1'b1, sar_pkg::A_CTRL, 32'h08);
        rdc("start_off", sar_pkg::A_CTRL, 32'h0);
        apb(1'b1, sar_pkg::A_CTRL, 32'h40);
        @(posedge sys_clk);
        chk("ref_on", 32'h1, {31'h0, ana_ref_on});
        $display("test enable done");
        test_done();
    end
endmodule : sar_converter_control_tb_top
